//--- bench/regulator_power_ctrl_props.sv
// Purpose: checker for regulator power control
// Assumes: one clock, sync reset
// Notes: bound to the design
`timescale 1ns/100ps
`include "regulator_power_regs.svh"
module regulator_power_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  // power
  input wire logic i_fetch_req,
  input wire logic i_prefetch_enable,
  input wire logic i_mem_stable,
  input wire logic i_stop_mode,
  input wire regulator_power_pkg::regulator_ctrl_s o_reg_ctrl,
  input wire logic o_reset_sources_live,
  input wire logic o_mem_power_on,
  input wire logic o_fetch_stall
);
  // ****
  // properties
  // ****
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  wire logic wr_hit = i_sfr_wr && i_sfr_addr == `REG_PWR_CTRL_ADDR;
  wire logic rd_hit = i_sfr_rd && i_sfr_addr == `REG_PWR_CTRL_ADDR;
  logic [5:0] stall_q;
  always_ff @(posedge i_clock)
    stall_q <= (i_reset || !o_fetch_stall) ? 6'h00 : stall_q + 6'h01;
  // shadow of the stop field and the expected live flag
  logic stop_cfg_q;
  logic live_exp_q;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stop_cfg_q <= 1'b0;
      live_exp_q <= 1'b1;
    end else begin
      if (wr_hit)
        stop_cfg_q <= i_sfr_wdata[`FLD_STOP_SHUTDOWN];
      live_exp_q <= !(i_stop_mode && stop_cfg_q);
    end
  end
  sequence s_wr;
    wr_hit ##1 !wr_hit;
  endsequence
  sequence s_settled;
    o_fetch_stall && i_mem_stable;
  endsequence
  property p_ctrl;
    s_wr |=> {o_reg_ctrl.input_reg_off, o_reg_ctrl.input_reg_lp,
      o_reg_ctrl.core_reg_lp} == $past({i_sfr_wdata[7], i_sfr_wdata[4],
      i_sfr_wdata[1]}, 2);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control lags write");
  property p_live;
    o_reg_ctrl.core_reg_off == !o_reset_sources_live;
  endproperty
  a_live: assert property (p_live)
    else $error("live flag wrong");
  property p_rdwr;
    s_wr ##0 rd_hit |=>
      (o_sfr_rdata & 8'hBF) == ($past(i_sfr_wdata, 2) & 8'hBF);
  endproperty
  a_rdwr: assert property (p_rdwr)
    else $error("readback wrong");
  property p_rdhold;
    !rd_hit |=> $stable(o_sfr_rdata);
  endproperty
  a_rdhold: assert property (p_rdhold)
    else $error("read data moved");
  property p_fetch;
    i_fetch_req |=> o_mem_power_on;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("memory off at fetch");
  property p_pref;
    i_prefetch_enable [*2] |-> o_mem_power_on;
  endproperty
  a_pref: assert property (p_pref)
    else $error("gated with prefetch");
  property p_son;
    o_fetch_stall |-> o_mem_power_on;
  endproperty
  a_son: assert property (p_son)
    else $error("stall without power");
  property p_smax;
    o_fetch_stall |-> stall_q < 6'h14;
  endproperty
  a_smax: assert property (p_smax)
    else $error("stall too long");
  property p_send;
    s_settled |-> ##[1:2] !o_fetch_stall;
  endproperty
  a_send: assert property (p_send)
    else $error("stall kept");
  property p_stopcfg;
    o_reset_sources_live == live_exp_q &&
      o_reg_ctrl.core_reg_off == !live_exp_q;
  endproperty
  a_stopcfg: assert property (p_stopcfg)
    else $error("stop regulator control wrong");
endmodule // regulator_power_props
bind regulator_power_ctrl regulator_power_props u_props (.i_clock,
  .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
  .i_fetch_req, .i_prefetch_enable, .i_mem_stable, .i_stop_mode, .o_reg_ctrl,
  .o_reset_sources_live, .o_mem_power_on, .o_fetch_stall);

//--- bench/tb_regulator_stop_memory_power_ctrl.sv
// Purpose: bench for regulator power control
// Assumes: inputs driven at falling edge
// Notes: sense held steady around reads
`timescale 1ns/100ps
`include "regulator_power_regs.svh"
module tb_regulator_stop_memory_power_ctrl;
  // ****
  // bench
  // ****
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_bus_power_sense = 1'b0;
  logic i_stop_mode = 1'b0;
  logic i_prefetch_enable = 1'b0;
  logic i_fetch_req = 1'b1;
  logic i_clock_fast = 1'b0;
  logic i_mem_stable = 1'b0;
  logic [7:0] o_sfr_rdata;
  regulator_power_pkg::regulator_ctrl_s o_reg_ctrl;
  logic o_reset_sources_live;
  logic o_mem_power_on;
  logic o_fetch_stall;
  logic [7:0] adr = `REG_PWR_CTRL_ADDR;
  int n_errors = 0;
  int compares = 0;
  int m;
  int k;
  int model_reg = 0;
  logic [7:0] seen_ctrl;
  logic [7:0] seen_mem;
  assign seen_ctrl = {3'h0, o_reg_ctrl, o_reset_sources_live};
  assign seen_mem = {6'h00, o_mem_power_on, o_fetch_stall};
  always #2 i_clock = ~i_clock;
  regulator_power_ctrl DUT (.i_clock, .i_reset, .i_sfr_addr, .i_sfr_wr,
    .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .i_bus_power_sense,
    .i_stop_mode, .i_prefetch_enable, .i_fetch_req, .i_clock_fast,
    .i_mem_stable, .o_reg_ctrl, .o_reset_sources_live, .o_mem_power_on,
    .o_fetch_stall);
  task automatic chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge i_clock);
  endtask
  // model: stored byte with the status bit set from bus power sense
  function automatic logic [7:0] model_rd();
    return 8'(model_reg) | {1'b0, i_bus_power_sense, 6'h00};
  endfunction
  function automatic logic [7:0] model_ctrl();
    logic off;
    off = i_stop_mode & model_reg[3];
    return {3'h0, model_reg[7], model_reg[4], model_reg[1], off, ~off};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    if (a == `REG_PWR_CTRL_ADDR)
      model_reg = int'(d & 8'hBF);
    cyc(1);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
  endtask
  // write, then read in the very next cycle
  task automatic wr_rd(input logic [7:0] a, d);
    if (a == `REG_PWR_CTRL_ADDR)
      model_reg = int'(d & 8'hBF);
    cyc(1);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b1;
    cyc(1);
    i_sfr_rd = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    cyc(1);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    cyc(1);
    i_sfr_rd = 1'b0;
    cyc(1);
  endtask
  task automatic mem(input logic [7:0] e);
    cyc(3);
    chk("mem", seen_mem, e);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hE906A7F1));
    cyc(5);
    i_reset = 1'b0;
    rd(adr);
    chk("rd0", o_sfr_rdata, 8'h00);
    chk("rst", seen_ctrl, model_ctrl());
    chk("rstm", seen_mem, 8'h02);
    for (k = 0; k < 16; k++) begin
      m = $urandom;
      m[1] = m[1] & ~m[7];
      i_bus_power_sense = m[8];
      i_stop_mode = m[9];
      wr(adr, m[7:0]);
      wr(8'hC8, ~m[7:0]);
      rd(adr);
      chk("rdata", o_sfr_rdata, model_rd());
      chk("ctrl", seen_ctrl, model_ctrl());
      rd(8'hC8);
      chk("hold", o_sfr_rdata, model_rd());
    end
    for (k = 0; k < 4; k++) begin
      m = $urandom;
      m[1] = m[1] & ~m[7];
      wr_rd(adr, m[7:0]);
      chk("b2b", o_sfr_rdata, model_rd());
    end
    i_stop_mode = 1'b0;
    wr(adr, 8'h01);
    i_fetch_req = 1'b0;
    mem(8'h00);
    i_prefetch_enable = 1'b1;
    mem(8'h02);
    i_prefetch_enable = 1'b0;
    mem(8'h00);
    i_fetch_req = 1'b1;
    mem(8'h02);
    wr(adr, 8'h00);
    i_fetch_req = 1'b0;
    mem(8'h02);
    wr(adr, 8'h01);
    i_fetch_req = 1'b1;
    i_clock_fast = 1'b1;
    k = 0;
    repeat (30) begin
      cyc(1);
      if (o_fetch_stall === 1'b1)
        k++;
    end
    chk("skip", 8'(k), 8'(`MAX_SKIP_CLOCKS));
    mem(8'h02);
    i_clock_fast = 1'b0;
    cyc(2);
    i_clock_fast = 1'b1;
    mem(8'h03);
    i_mem_stable = 1'b1;
    mem(8'h02);
    i_reset = 1'b1;
    cyc(2);
    i_reset = 1'b0;
    model_reg = 0;
    rd(adr);
    chk("rst2", o_sfr_rdata, model_rd());
    chk("rst2c", seen_ctrl, model_ctrl());
    chk("rst2m", seen_mem, 8'h02);
    tally_and_finish;
  end
endmodule // tb_regulator_stop_memory_power_ctrl

//--- core/mem_power_gate.sv
// Purpose: program memory power gating with wake stall
// Assumes: fetch request is known one cycle ahead of the read
// Notes: stall lasts until stable, at most the skip limit
`timescale 1ns/100ps
`include "regulator_power_regs.svh"

module mem_power_gate (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // control
  input wire logic i_gate_enable,
  input wire logic i_fetch_req,
  input wire logic i_clock_fast,
  input wire logic i_mem_stable,
  // status
  output logic o_mem_power_on,
  output logic o_fetch_stall
);

  // ********************************
  // state and skip counter
  // ********************************
  regulator_power_pkg::mem_pwr_state_e state_q;
  regulator_power_pkg::mem_pwr_state_e state_d;
  logic [`SKIP_CNT_W-1:0] skip_q;
  logic [`SKIP_CNT_W-1:0] skip_d;
  logic fast_q;
  logic slow_to_fast;
  logic skip_done;

  assign slow_to_fast = i_clock_fast & ~fast_q;
  assign skip_done = i_mem_stable |
    (skip_q == `SKIP_CNT_W'(`MAX_SKIP_CLOCKS - 1));

  always_comb begin
    state_d = state_q;
    skip_d = skip_q;
    unique case (state_q)
      regulator_power_pkg::MEM_ON: begin
        if (i_gate_enable && slow_to_fast) begin
          state_d = regulator_power_pkg::MEM_WAKE;
          skip_d = '0;
        end else if (i_gate_enable && !i_fetch_req) begin
          state_d = regulator_power_pkg::MEM_GATED;
        end
      end
      regulator_power_pkg::MEM_GATED: begin
        if (!i_gate_enable || i_fetch_req) begin
          state_d = regulator_power_pkg::MEM_ON;
        end
        if (i_gate_enable && slow_to_fast) begin
          state_d = regulator_power_pkg::MEM_WAKE;
          skip_d = '0;
        end
      end
      regulator_power_pkg::MEM_WAKE: begin
        skip_d = skip_q + `SKIP_CNT_W'(1);
        if (skip_done || !i_gate_enable) begin
          state_d = regulator_power_pkg::MEM_ON;
        end
      end
      default: state_d = regulator_power_pkg::MEM_ON;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= regulator_power_pkg::MEM_ON;
      skip_q <= '0;
      fast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      skip_q <= skip_d;
      fast_q <= i_clock_fast;
    end
  end

  // ********************************
  // outputs
  // ********************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_mem_power_on <= 1'b1;
      o_fetch_stall <= 1'b0;
    end else begin
      o_mem_power_on <= (state_d != regulator_power_pkg::MEM_GATED);
      o_fetch_stall <= (state_d == regulator_power_pkg::MEM_WAKE);
    end
  end

endmodule // mem_power_gate

//--- core/regulator_power_ctrl.sv
// Purpose: regulator and program memory power control register
// Assumes: special-function register bus, one clock, synchronous reset
// Notes: register read data is registered one cycle after the read strobe
`timescale 1ns/100ps
`include "regulator_power_regs.svh"

// Function
// - stop shutdown clear: core regulator stays on in stop, resets still work
// - stop shutdown set: core regulator off in stop, only pin or power reset
// - bit 1 selects core regulator normal or low-power mode
// - memory power enable gates program memory off between fetches
// - enable clear keeps memory on; set switches it per access
// - memory power enable ignored while prefetch engine runs
// - slow-to-fast clock change may skip up to 20 clocks
// - bit 7 disables the input regulator when set
// - bit 6 reads bus power sense level, read only
// - bit 4 puts input regulator into low-power suspend mode
module regulator_power_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // special-function register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // system status
  input wire logic i_bus_power_sense,
  input wire logic i_stop_mode,
  input wire logic i_prefetch_enable,
  input wire logic i_fetch_req,
  input wire logic i_clock_fast,
  input wire logic i_mem_stable,
  // power controls
  output regulator_power_pkg::regulator_ctrl_s o_reg_ctrl,
  output logic o_reset_sources_live,
  output logic o_mem_power_on,
  output logic o_fetch_stall
);

  // ********************************
  // register storage
  // ********************************
  regulator_power_pkg::regulator_power_control_s ctrl_q;
  regulator_power_pkg::regulator_power_control_s ctrl_d;
  regulator_power_pkg::regulator_power_control_s rd_image;
  regulator_power_pkg::regulator_ctrl_s reg_ctrl_d;
  logic bus_power_q;
  logic addr_hit;
  logic wr_hit;
  logic rd_hit;
  logic gate_enable;
  logic core_off;

  assign addr_hit = (i_sfr_addr == `REG_PWR_CTRL_ADDR);
  assign wr_hit = addr_hit & i_sfr_wr;
  assign rd_hit = addr_hit & i_sfr_rd;

  // writable bits; bit 6 is status only
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_hit) begin
      ctrl_d = i_sfr_wdata;
      ctrl_d.bus_power_status = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_q <= `REG_PWR_CTRL_RESET;
      bus_power_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      bus_power_q <= i_bus_power_sense;
    end
  end

  // ********************************
  // register read
  // ********************************
  always_comb begin
    rd_image = ctrl_q;
    rd_image.bus_power_status = bus_power_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (rd_hit) begin
      o_sfr_rdata <= rd_image;
    end
  end

  // ********************************
  // regulator controls
  // ********************************
  assign core_off = i_stop_mode & ctrl_q.stop_regulator_shutdown;

  always_comb begin
    reg_ctrl_d.input_reg_off = ctrl_q.input_reg_disable;
    reg_ctrl_d.input_reg_lp = ctrl_q.input_reg_low_power_sel;
    // no interlock against disabled input regulator
    reg_ctrl_d.core_reg_lp = ctrl_q.core_reg_low_power_sel;
    reg_ctrl_d.core_reg_off = core_off;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_ctrl <= '0;
      o_reset_sources_live <= 1'b1;
    end else begin
      o_reg_ctrl <= reg_ctrl_d;
      o_reset_sources_live <= ~core_off;
    end
  end

  // ********************************
  // program memory power
  // ********************************
  assign gate_enable = ctrl_q.memory_power_ctrl_enable &
    ~i_prefetch_enable;

  mem_power_gate u_mem_power_gate (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_gate_enable(gate_enable),
    .i_fetch_req(i_fetch_req),
    .i_clock_fast(i_clock_fast),
    .i_mem_stable(i_mem_stable),
    .o_mem_power_on(o_mem_power_on),
    .o_fetch_stall(o_fetch_stall)
  );

endmodule // regulator_power_ctrl

//--- core/regulator_power_pkg.sv
// Purpose: types for the regulator and memory power control block
// Assumes: nothing beyond the register header
// Notes: types only
package regulator_power_pkg;

  // ********************************
  // register image
  // ********************************
  typedef struct packed {
    logic input_reg_disable;
    logic bus_power_status;
    logic rsvd_hi;
    logic input_reg_low_power_sel;
    logic stop_regulator_shutdown;
    logic rsvd_lo;
    logic core_reg_low_power_sel;
    logic memory_power_ctrl_enable;
  } regulator_power_control_s;

  // ********************************
  // regulator controls to analog side
  // ********************************
  typedef struct packed {
    logic input_reg_off;
    logic input_reg_lp;
    logic core_reg_lp;
    logic core_reg_off;
  } regulator_ctrl_s;

  // ********************************
  // memory power states
  // ********************************
  typedef enum logic [1:0] {
    MEM_ON,
    MEM_GATED,
    MEM_WAKE
  } mem_pwr_state_e;

endpackage

//--- core/regulator_power_regs.svh
// Purpose: constants for the regulator and memory power control register
// Assumes: 8-bit special-function register bus, 250 MHz system clock
// Notes: definitions only
`ifndef REGULATOR_POWER_REGS_SVH
`define REGULATOR_POWER_REGS_SVH

// ********************************
// register address and reset
// ********************************
`define REG_PWR_CTRL_ADDR 8'hC9
`define REG_PWR_CTRL_RESET 8'h00

// ********************************
// field positions
// ********************************
`define FLD_MEM_PWR_EN 0
`define FLD_CORE_LP_SEL 1
`define FLD_RSVD_LO 2
`define FLD_STOP_SHUTDOWN 3
`define FLD_INPUT_LP_SEL 4
`define FLD_RSVD_HI 5
`define FLD_BUS_POWER 6
`define FLD_INPUT_DISABLE 7

// ********************************
// timing
// ********************************
`define MAX_SKIP_CLOCKS 20
`define SKIP_CNT_W 5

`endif
